// >>> sdl_pkg.sv
// Constants, field layouts and carrier types of the synthesizer control block.
`default_nettype none

package sdl_pkg;

    // ==========================================================================
    // Reference divider
    // ==========================================================================
    localparam int REF_FREQ_KHZ = 12800;
    localparam int CMP_5K_HZ = 5000;
    localparam int CMP_6K25_HZ = 6250;
    localparam int REF_CNT_W = 12;
    localparam logic [REF_CNT_W-1:0] REF_DIV_5K = 12'(REF_FREQ_KHZ * 1000 / CMP_5K_HZ);
    localparam logic [REF_CNT_W-1:0] REF_DIV_6K25 = 12'(REF_FREQ_KHZ * 1000 / CMP_6K25_HZ);

    // ==========================================================================
    // Serial load word
    // ==========================================================================
    localparam int SHIFT_W = 20;
    localparam int WSEL_HI = 19;
    localparam int WSEL_LO = 18;
    localparam int RATIO_W = 16;
    localparam logic [1:0] WSEL_REF = 2'h0;
    localparam logic [1:0] WSEL_RATIO = 2'h1;
    localparam logic [1:0] WSEL_LEVEL = 2'h2;

    // Pin indices of the synchronised input group.
    localparam int PIN_SDATA = 0;
    localparam int PIN_SCLK = 1;
    localparam int PIN_STB = 2;
    localparam int PIN_OSC = 3;
    localparam int PIN_N = 4;

    // ==========================================================================
    // Output power codes and drive levels
    // ==========================================================================
    localparam logic [1:0] LVL_LOW = 2'h0;
    localparam logic [1:0] LVL_MID = 2'h1;
    localparam logic [1:0] LVL_HIGH = 2'h2;
    localparam logic [7:0] DRV_OFF = 8'h00;
    localparam logic [7:0] DRV_LOW = 8'h20;
    localparam logic [7:0] DRV_MID = 8'h80;
    localparam logic [7:0] DRV_HIGH = 8'hff;

    // ==========================================================================
    // Register map
    // ==========================================================================
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_RATIO = 8'h08;
    localparam logic [7:0] REG_IRQ_STAT = 8'h0c;
    localparam logic [7:0] REG_IRQ_MASK = 8'h10;
    localparam int CTRL_TX = 0;
    localparam int ST_UNLOCK = 0;
    localparam int ST_TX = 1;
    localparam int ST_REF_SEL = 2;
    localparam int ST_LVL_LO = 4;
    localparam int ST_PUMP_UP = 8;
    localparam int ST_PUMP_DN = 9;
    localparam int IRQ_W = 3;
    localparam int IRQ_UNLOCK = 0;
    localparam int IRQ_LOAD = 1;
    localparam int IRQ_TX_INHIBIT = 2;

    // ==========================================================================
    // Reset values
    // ==========================================================================
    localparam logic RST_REF_SEL = 1'b0;
    localparam logic [RATIO_W-1:0] RST_RATIO = 16'h0100;
    localparam logic [1:0] RST_LEVEL = LVL_LOW;

    typedef struct packed {
        logic ref_sel;
        logic [RATIO_W-1:0] ratio;
        logic [1:0] level;
    } sdl_cfg_t;

    typedef struct packed {
        logic up;
        logic dn;
    } sdl_pfd_t;

endpackage

`default_nettype wire

// >>> sdl_synth_ctrl.sv
// Synthesizer control: serial load, dividers, phase comparator, lock and power inhibit.
//
// Operation
// - Reference divides by 2560 or 2048.
// - Oscillator divided by loaded ratio.
// - Comparator pulses width track phase error.
// - Serial shift, then parallel latch drives dividers.
// - Unlock follows presence of phase difference.
// - Unlock in transmit zeroes power level.
// - Receive holds power level at zero.
// - Power code latched, mapped to level reference.
`timescale 1ns/1ps
`default_nettype none

module sdl_synth_ctrl
    import sdl_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // Serial configuration from the host
    input wire logic ser_data_i,
    input wire logic ser_clk_i,
    input wire logic ser_strobe_i,
    // Oscillator sample
    input wire logic osc_i,
    // Loop, power and interrupt outputs
    output logic pump_up_o,
    output logic pump_dn_o,
    output logic unlock_o,
    output logic [7:0] tx_level_control_loop_o,
    output logic irq_o
);

    // ==========================================================================
    // Helpers
    // ==========================================================================
    function automatic logic [REF_CNT_W-1:0] ref_reload(input logic sel);
        ref_reload = sel ? (REF_DIV_6K25 - 12'd1) : (REF_DIV_5K - 12'd1);
    endfunction

    function automatic logic [7:0] level_drive(input logic [1:0] code);
        unique case (code)
            LVL_HIGH: level_drive = DRV_HIGH;
            LVL_MID: level_drive = DRV_MID;
            default: level_drive = DRV_LOW;
        endcase
    endfunction

    // ==========================================================================
    // Pin synchronisers
    // ==========================================================================
    logic [PIN_N-1:0] meta_r;
    logic [PIN_N-1:0] sync_r;
    logic [PIN_N-1:0] prev_r;

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            meta_r <= '0;
            sync_r <= '0;
            prev_r <= '0;
        end
        else
        begin
            meta_r <= {osc_i, ser_strobe_i, ser_clk_i, ser_data_i};
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    logic sclk_rise;
    logic stb_rise;
    logic osc_rise;
    assign sclk_rise = sync_r[PIN_SCLK] & ~prev_r[PIN_SCLK];
    assign stb_rise = sync_r[PIN_STB] & ~prev_r[PIN_STB];
    assign osc_rise = sync_r[PIN_OSC] & ~prev_r[PIN_OSC];

    // ==========================================================================
    // Serial shift register and parallel latch
    // ==========================================================================
    logic [SHIFT_W-1:0] shift_r;
    logic [1:0] shift_sel;
    logic [RATIO_W-1:0] shift_ratio;
    sdl_cfg_t cfg_r;

    assign shift_sel = shift_r[WSEL_HI:WSEL_LO];
    assign shift_ratio = shift_r[RATIO_W-1:0];

    // Data and clock share the same synchroniser depth, so the sampled bit
    // is the one the host held while raising its shift clock.
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            shift_r <= '0;
        else if (sclk_rise)
            shift_r <= {shift_r[SHIFT_W-2:0], sync_r[PIN_SDATA]};
    end

    // The whole field moves in one step on the strobe, so a divider never
    // sees a half-shifted value.
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            cfg_r.ref_sel <= RST_REF_SEL;
            cfg_r.ratio <= RST_RATIO;
            cfg_r.level <= RST_LEVEL;
        end
        else if (stb_rise)
        begin
            unique case (shift_sel)
                WSEL_REF: cfg_r.ref_sel <= shift_r[0];
                WSEL_RATIO: cfg_r.ratio <= shift_ratio;
                WSEL_LEVEL: cfg_r.level <= shift_r[1:0];
                default: cfg_r <= cfg_r;
            endcase
        end
    end

    // ==========================================================================
    // Reference divider
    // ==========================================================================
    logic [REF_CNT_W-1:0] ref_cnt_r;
    logic ref_tick;
    assign ref_tick = (ref_cnt_r == '0);

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            ref_cnt_r <= '0;
        else if (ref_tick)
            ref_cnt_r <= ref_reload(cfg_r.ref_sel);
        else
            ref_cnt_r <= ref_cnt_r - 12'd1;
    end

    // ==========================================================================
    // Comparative divider
    // ==========================================================================
    logic [RATIO_W-1:0] div_cnt_r;
    logic div_tick;
    assign div_tick = osc_rise & (div_cnt_r == '0);

    // A ratio of zero is treated as one rather than stalling the loop.
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            div_cnt_r <= '0;
        else if (div_tick)
            div_cnt_r <= (cfg_r.ratio == '0) ? '0 : cfg_r.ratio - 16'd1;
        else if (osc_rise)
            div_cnt_r <= div_cnt_r - 16'd1;
    end

    // ==========================================================================
    // Phase comparator and lock detector
    // ==========================================================================
    sdl_pfd_t pfd_r;
    sdl_pfd_t pfd_nxt;
    logic unlock_r;
    logic unlock_nxt;

    always_comb
    begin
        pfd_nxt.up = pfd_r.up | ref_tick;
        pfd_nxt.dn = pfd_r.dn | div_tick;
        if (pfd_nxt.up & pfd_nxt.dn)
        begin
            pfd_nxt.up = 1'b0;
            pfd_nxt.dn = 1'b0;
        end
    end

    assign unlock_nxt = pfd_r.up | pfd_r.dn;

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            pfd_r <= '0;
            unlock_r <= 1'b0;
        end
        else
        begin
            pfd_r <= pfd_nxt;
            unlock_r <= unlock_nxt;
        end
    end

    assign pump_up_o = pfd_r.up;
    assign pump_dn_o = pfd_r.dn;
    assign unlock_o = unlock_r;

    // ==========================================================================
    // Transmit mode and power level
    // ==========================================================================
    logic tx_mode_r;
    logic [7:0] level_r;
    logic wr_ctrl;
    assign wr_ctrl = reg_wr_i & (reg_addr_i == REG_CTRL);

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            tx_mode_r <= 1'b0;
        else if (wr_ctrl)
            tx_mode_r <= reg_wdata_i[CTRL_TX];
    end

    // Receive and unlock share one inhibit path, so both force the same zero.
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            level_r <= DRV_OFF;
        else if (!tx_mode_r || unlock_r)
            level_r <= DRV_OFF;
        else
            level_r <= level_drive(cfg_r.level);
    end

    assign tx_level_control_loop_o = level_r;

    // ==========================================================================
    // Interrupts
    // ==========================================================================
    logic [IRQ_W-1:0] irq_stat_r;
    logic [IRQ_W-1:0] irq_mask_r;
    logic [IRQ_W-1:0] irq_evt;
    logic [IRQ_W-1:0] irq_clr;

    always_comb
    begin
        irq_evt = '0;
        irq_evt[IRQ_UNLOCK] = unlock_nxt & ~unlock_r;
        irq_evt[IRQ_LOAD] = stb_rise;
        irq_evt[IRQ_TX_INHIBIT] = unlock_nxt & ~unlock_r & tx_mode_r;
    end

    assign irq_clr = (reg_wr_i && reg_addr_i == REG_IRQ_STAT) ? reg_wdata_i[IRQ_W-1:0] : '0;

    // An event in the clearing cycle survives: the set term is applied last.
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            irq_stat_r <= '0;
        else
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_evt;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            irq_mask_r <= '0;
        else if (reg_wr_i && reg_addr_i == REG_IRQ_MASK)
            irq_mask_r <= reg_wdata_i[IRQ_W-1:0];
    end

    assign irq_o = |(irq_stat_r & irq_mask_r);

    // ==========================================================================
    // Register read port
    // ==========================================================================
    logic [31:0] rd_mux;
    logic [31:0] rdata_r;

    always_comb
    begin
        rd_mux = '0;
        unique case (reg_addr_i)
            REG_CTRL: rd_mux[CTRL_TX] = tx_mode_r;
            REG_STATUS:
            begin
                rd_mux[ST_UNLOCK] = unlock_r;
                rd_mux[ST_TX] = tx_mode_r;
                rd_mux[ST_REF_SEL] = cfg_r.ref_sel;
                rd_mux[ST_LVL_LO+:2] = cfg_r.level;
                rd_mux[ST_PUMP_UP] = pfd_r.up;
                rd_mux[ST_PUMP_DN] = pfd_r.dn;
            end
            REG_RATIO: rd_mux[RATIO_W-1:0] = cfg_r.ratio;
            REG_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat_r;
            REG_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask_r;
            default: rd_mux = '0;
        endcase
    end

    // Read data stand for exactly one cycle and are zero otherwise.
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            rdata_r <= '0;
        else if (reg_rd_i)
            rdata_r <= rd_mux;
        else
            rdata_r <= '0;
    end

    assign reg_rdata_o = rdata_r;

    // ==========================================================================
    // Assertions
    // ==========================================================================
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    sequence ratio_load_s;
        stb_rise && (shift_sel == WSEL_RATIO);
    endsequence

    sequence level_load_s;
        stb_rise && (shift_sel == WSEL_LEVEL);
    endsequence

    sequence both_phases_s;
        pfd_r.dn && ref_tick;
    endsequence

    ref_reload_a: assert property (ref_tick |=> ref_cnt_r == ($past(cfg_r.ref_sel) ? 12'd2047 : 12'd2559))
        else $error("reference divider reloaded with wrong count");

    div_reload_a: assert property (div_tick && cfg_r.ratio != '0 |=> div_cnt_r + 16'd1 == $past(cfg_r.ratio))
        else $error("comparative divider reloaded with wrong ratio");

    pfd_lead_a: assert property (ref_tick && !pfd_r.dn && !div_tick |=> pump_up_o && !pump_dn_o)
        else $error("reference edge did not raise the up pulse");

    pfd_cancel_a: assert property (both_phases_s |=> !pump_up_o && !pump_dn_o)
        else $error("up and down pulses did not cancel");

    unlock_track_a: assert property ((pump_up_o || pump_dn_o) |=> unlock_o)
        else $error("phase difference did not assert unlock");

    lock_clear_a: assert property (!pump_up_o && !pump_dn_o |=> !unlock_o)
        else $error("unlock stayed high without phase difference");

    tx_inhibit_a: assert property (unlock_o |=> tx_level_control_loop_o == DRV_OFF)
        else $error("power level not zero while unlocked");

    rx_hold_a: assert property (!tx_mode_r [*2] |-> tx_level_control_loop_o == DRV_OFF)
        else $error("power level not zero in receive");

    ratio_latch_a: assert property (ratio_load_s |=> cfg_r.ratio == $past(shift_ratio))
        else $error("strobe did not latch the divider ratio");

    level_map_a: assert property (level_load_s ##1 (tx_mode_r && !unlock_r && cfg_r.level == LVL_HIGH)
        |=> tx_level_control_loop_o == DRV_HIGH)
        else $error("high power code not mapped to full level");

    irq_hold_a: assert property (irq_evt[IRQ_LOAD] |=> irq_stat_r[IRQ_LOAD])
        else $error("load event lost from status");

    rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0000_0000)
        else $error("read data stood outside the read answer cycle");

endmodule

`default_nettype wire

// >>> sdl_host_model.sv
// Host model: serial loader and oscillator stimulus for the synthesizer block.
`timescale 1ns/1ps
`default_nettype none

module sdl_host_model
    import sdl_pkg::*;
(
    // Clock
    input wire logic ref_clk_i,
    // Pins toward the block
    output logic ser_data_o,
    output logic ser_clk_o,
    output logic ser_strobe_o,
    output logic osc_o
);
    // ====================
    // Pin drivers
    // ====================
    initial
    begin
        ser_data_o = 1'b0;
        ser_clk_o = 1'b0;
        ser_strobe_o = 1'b0;
        osc_o = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask

    // Each level is held four clocks because the pins pass a two-stage synchroniser.
    task automatic load(input logic [SHIFT_W-1:0] w);
        for (int i = SHIFT_W - 1; i >= 0; i--)
        begin
            ser_data_o <= w[i];
            wait_clk(4);
            ser_clk_o <= 1'b1;
            wait_clk(4);
            ser_clk_o <= 1'b0;
            wait_clk(4);
        end
        ser_data_o <= ~w[0];
        ser_strobe_o <= 1'b1;
        wait_clk(4);
        ser_strobe_o <= 1'b0;
        wait_clk(4);
    endtask

    // The step is in units of 100 Hz; steps that are multiples of 12.5 kHz use 6.25 kHz.
    task automatic set_rate(input int step, input logic [RATIO_W-1:0] ratio);
        load({WSEL_REF, 17'h0, step % 125 == 0});
        load({WSEL_RATIO, 2'h0, ratio});
    endtask

    task automatic osc_pulse();
        osc_o <= 1'b1;
        wait_clk(4);
        osc_o <= 1'b0;
        wait_clk(4);
    endtask
endmodule

`default_nettype wire

// >>> sdl_synth_ctrl_tb.sv
// Self-checking testbench of the synthesizer control block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) \
        begin \
            fail_count++; \
            $display("Error %s exp %h got %h", what, exp, got); \
        end \
    end

module sdl_synth_ctrl_tb
    import sdl_pkg::*;
;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic ser_data_i, ser_clk_i, ser_strobe_i, osc_i;
    logic pump_up_o, pump_dn_o, unlock_o, irq_o;
    logic [7:0] tx_level_control_loop_o;
    int fail_count = 0;
    int n_compared = 0;
    int cyc = 0;
    logic rd_q = 1'b0;
    logic [63:0] exp_q[$];
    logic [63:0] e;
    int steps[7] = '{50, 100, 150, 200, 125, 250, 500};
    logic [7:0] lvl[4] = '{DRV_LOW, DRV_MID, DRV_HIGH, DRV_LOW};

    always #20 ref_clk_i = ~ref_clk_i;

    sdl_host_model sdl_host_model_i (
        .ref_clk_i,
        .ser_data_o(ser_data_i),
        .ser_clk_o(ser_clk_i),
        .ser_strobe_o(ser_strobe_i),
        .osc_o(osc_i)
    );

    sdl_synth_ctrl sdl_synth_ctrl_i (
        .ref_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o, .ser_data_i, .ser_clk_i, .ser_strobe_i, .osc_i,
        .pump_up_o, .pump_dn_o, .unlock_o, .tx_level_control_loop_o, .irq_o
    );

    // ====================
    // Read monitor and timeout
    // ====================
    always @(posedge ref_clk_i)
    begin
        cyc <= cyc + 1;
        rd_q <= reg_rd_i;
        if (rd_q)
        begin
            e = exp_q.pop_front();
            `CHK("rdata", e[31:0], reg_rdata_o & e[63:32])
        end
        if (cyc == 80000)
        begin
            fail_count++;
            stop_test();
        end
    end

    // ====================
    // Tasks
    // ====================
    task automatic stop_test();
        $display("compared %0d failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic done(input string s);
        $display("test %s done", s);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask

    // The note holds the mask of the bits that matter beside the expected value.
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        exp_q.push_back({m, x & m});
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask

    task automatic wait_up();
        for (int n = 0; n < 3000 && pump_up_o !== 1'b1; n++)
            @(posedge ref_clk_i);
        `CHK("up seen", 1'b1, pump_up_o)
    endtask

    task automatic clear_up();
        for (int i = 0; i < 20 && pump_up_o === 1'b1; i++)
            sdl_host_model_i.osc_pulse();
        repeat (3) @(posedge ref_clk_i);
        `CHK("up clear", 1'b0, pump_up_o)
    endtask

    // ====================
    // Main sequence
    // ====================
    initial
    begin
        logic [RATIO_W-1:0] r;
        int c0;
        int n;
        void'($urandom(20698));
        repeat (5) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        `CHK("level rst", DRV_OFF, tx_level_control_loop_o)
        `CHK("unlock rst", 1'b0, unlock_o)
        rd(REG_RATIO, 32'hffff, 32'(RST_RATIO));
        rd(REG_STATUS, 32'h36, 32'h0);
        rd(REG_IRQ_MASK, 32'h7, 32'h0);
        rd(8'h14, 32'hffffffff, 32'h0);
        done("reset");

        r = 16'($urandom_range(2, 16'hffff));
        wr(REG_IRQ_MASK, 32'h2);
        wr(REG_IRQ_STAT, 32'h7);
        `CHK("irq idle", 1'b0, irq_o)
        sdl_host_model_i.load({WSEL_RATIO, 2'h0, r});
        `CHK("irq load", 1'b1, irq_o)
        wr(REG_RATIO, 32'h5);
        wr(REG_IRQ_MASK, 32'h0);
        `CHK("irq masked", 1'b0, irq_o)
        sdl_host_model_i.load({2'h3, 18'h5});
        rd(REG_RATIO, 32'hffff, 32'(r));
        rd(REG_IRQ_STAT, 32'h2, 32'h2);
        wr(REG_IRQ_STAT, 32'h2);
        rd(REG_IRQ_STAT, 32'h2, 32'h0);
        done("serial load");

        foreach (steps[i])
        begin
            sdl_host_model_i.set_rate(steps[i], r);
            rd(REG_STATUS, 32'h4, {29'h0, 1'(i >= 4), 2'h0});
        end
        done("step select");

        sdl_host_model_i.load({WSEL_RATIO, 18'h1});
        for (int s = 0; s < 2; s++)
        begin
            sdl_host_model_i.load({WSEL_REF, 17'h0, 1'(s)});
            wait_up();
            clear_up();
            wait_up();
            c0 = cyc;
            clear_up();
            wait_up();
            `CHK("ref period", 32'(s ? REF_DIV_6K25 : REF_DIV_5K), 32'(cyc - c0))
        end
        done("reference divider");

        n = $urandom_range(2, 9);
        sdl_host_model_i.load({WSEL_RATIO, 18'(n)});
        wait_up();
        clear_up();
        wait_up();
        repeat (n - 1) sdl_host_model_i.osc_pulse();
        `CHK("up held", 1'b1, pump_up_o)
        sdl_host_model_i.osc_pulse();
        `CHK("up cleared", 1'b0, pump_up_o)
        // With no reference edge pending, a full ratio of oscillator edges leads.
        repeat (n) sdl_host_model_i.osc_pulse();
        `CHK("dn lead", 1'b1, pump_dn_o)
        for (int k = 0; k < 3000 && pump_dn_o === 1'b1; k++)
            @(posedge ref_clk_i);
        `CHK("dn cancel", 1'b0, pump_up_o | pump_dn_o)
        done("comparative divider");

        wr(REG_CTRL, 32'h1);
        rd(REG_CTRL, 32'h1, 32'h1);
        sdl_host_model_i.set_rate(100, 16'(n));
        for (int c = 0; c < 4; c++)
        begin
            sdl_host_model_i.load({WSEL_LEVEL, 16'h0, 2'(c)});
            wait_up();
            repeat (3) @(posedge ref_clk_i);
            `CHK("unlock", 1'b1, unlock_o)
            `CHK("inhibit", DRV_OFF, tx_level_control_loop_o)
            clear_up();
            `CHK("locked", 1'b0, unlock_o)
            `CHK("level", lvl[c], tx_level_control_loop_o)
        end
        wr(REG_CTRL, 32'h0);
        repeat (2) @(posedge ref_clk_i);
        `CHK("rx level", DRV_OFF, tx_level_control_loop_o)
        done("power control");

        for (int t = 1; t >= 0; t--)
        begin
            wr(REG_IRQ_MASK, 32'h1);
            wr(REG_CTRL, 32'(t));
            wr(REG_IRQ_STAT, 32'h7);
            `CHK("irq clear", 1'b0, irq_o)
            wait_up();
            repeat (3) @(posedge ref_clk_i);
            `CHK("irq unlock", 1'b1, irq_o)
            rd(REG_IRQ_STAT, 32'h5, {29'h0, 1'(t), 2'h1});
            clear_up();
        end
        done("unlock interrupt");
        stop_test();
    end
endmodule

`default_nettype wire
